// File: rtl/xbc_cfg.svh
// Purpose: timing and layout constants for the external bus controller
// Assumes: 100 MHz clk
// Notes: machine cycle split into fixed phases
`ifndef XBC_CFG_SVH
`define XBC_CFG_SVH
// ==========================================
// machine cycle phases (clocks)
`define XBC_CYC_LEN 5'h0f
`define XBC_ALE_END 5'h02
`define XBC_ADR_END 5'h04
`define XBC_STB_END 5'h0c
`define XBC_PORT_RST 8'hff
`define XBC_ROM_LIMIT 12'h400
`define XBC_PC_RST 12'h000
`define XBC_CLK_DIV 4'h2
`endif

// File: rtl/xbc_pkg.sv
// Purpose: types for the external bus controller
// Assumes: nothing
// Notes: request carried as one packed struct
`default_nettype none
package xbc_pkg;
    // ==========================================
    // request kinds
    typedef enum logic [2:0] {
        XBC_OP_NONE,
        XBC_OP_FETCH,
        XBC_OP_DRD,
        XBC_OP_DWR,
        XBC_OP_BUS_RD,
        XBC_OP_BUS_WR,
        XBC_OP_EXP
    } xbc_op_type;
    typedef struct packed {
        xbc_op_type op;
        logic [11:0] pc;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [3:0] exp_nib;
    } xbc_req_type;
endpackage : xbc_pkg
`default_nettype wire

// File: rtl/xbc_bus.sv
// Purpose: external bus and pin control of an 8-bit microcontroller
// Assumes: core issues one request per machine cycle, pins async
// Notes: ports written as latches; quasi-bidir port two pins modelled with oe, port one has no oe
`default_nettype none
`include "xbc_cfg.svh"
module xbc_bus (
    input wire logic clk,
    input wire logic srst,
    input wire xbc_pkg::xbc_req_type req,
    input wire logic clock_out_enable_instr,
    input wire logic start_counter_instr,
    input wire logic stop_counter_instr,
    input wire logic [7:0] port_one_wr,
    input wire logic port_one_we,
    input wire logic [7:0] port_two_wr,
    input wire logic port_two_we,
    output logic req_ready,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic [11:0] pc_cur,
    output logic internal_fetch,
    input wire logic [7:0] mux_bus_in,
    output logic [7:0] mux_bus_out,
    output logic mux_bus_oe,
    output logic addr_latch_strobe,
    output logic prog_store_strobe_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic expander_strobe_n,
    input wire logic [7:0] port_one_in,
    output logic [7:0] port_one_out,
    input wire logic [7:0] port_two_in,
    output logic [7:0] port_two_out,
    output logic [7:0] port_two_oe,
    input wire logic force_external_fetch,
    input wire logic single_step_n,
    input wire logic irq_n,
    input wire logic test_in_zero,
    input wire logic test_in_one,
    output logic test_zero_out,
    output logic test_zero_oe,
    output logic jump_on_test_zero,
    output logic jump_on_test_one,
    output logic irq_req,
    output logic jump_on_irq,
    output logic count_pulse,
    output logic [7:0] port_one_sync,
    output logic [7:0] port_two_sync
);
    // ==========================================
    // input synchronisers, change taken when stages 2 and 3 agree
    localparam int NSYNC = 21;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;
    assign raw_in = {port_two_in, port_one_in, force_external_fetch,
                     single_step_n, irq_n, test_in_zero, test_in_one};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge clk) begin
                s1_q[g] <= raw_in[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (srst) begin
                    filt_q[g] <= 1'b1;
                end else if (s2_q[g] == s3_q[g]) begin
                    filt_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate
    logic t1_s, t0_s, irqn_s, ssn_s, ea_s;
    assign t1_s = filt_q[0];
    assign t0_s = filt_q[1];
    assign irqn_s = filt_q[2];
    assign ssn_s = filt_q[3];
    assign ea_s = filt_q[4];

    // ==========================================
    // machine cycle sequencer
    typedef enum logic [1:0] {ST_RUN, ST_HALT} xbc_seq_type;
    xbc_seq_type seq_q;
    logic [4:0] ph_q;
    xbc_pkg::xbc_req_type cur_q;
    logic cyc_end;
    assign cyc_end = (ph_q == `XBC_CYC_LEN);

    function automatic logic is_ext_fetch(input xbc_pkg::xbc_req_type r, input logic ea);
        is_ext_fetch = (r.op == xbc_pkg::XBC_OP_FETCH) && (ea || (r.pc >= `XBC_ROM_LIMIT));
    endfunction : is_ext_fetch

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_q <= ST_RUN;
            ph_q <= 5'h00;
            cur_q <= '0;
            req_ready <= 1'b0;
        end else begin
            case (seq_q)
                ST_RUN: begin
                    if (cyc_end) begin
                        ph_q <= 5'h00;
                        cur_q <= req;
                        req_ready <= 1'b0;
                        // halt only at an instruction boundary, i.e. next fetch
                        if (!ssn_s && req.op == xbc_pkg::XBC_OP_FETCH) begin
                            seq_q <= ST_HALT;
                        end
                    end else begin
                        ph_q <= ph_q + 5'h01;
                        req_ready <= (ph_q == `XBC_CYC_LEN - 5'h01);
                    end
                end
                ST_HALT: begin
                    if (ssn_s) begin
                        seq_q <= ST_RUN;
                    end
                end
                default: seq_q <= ST_RUN;
            endcase
        end
    end

    // ==========================================
    // bus strobes; address strobe held low during halt for single step
    logic run_ph, adr_ph, stb_ph, ext_f, is_rd, is_wr;
    assign run_ph = (seq_q == ST_RUN);
    assign adr_ph = run_ph && (ph_q < `XBC_ADR_END);
    assign stb_ph = run_ph && (ph_q >= `XBC_ADR_END) && (ph_q < `XBC_STB_END);
    assign ext_f = is_ext_fetch(cur_q, ea_s);
    assign is_rd = (cur_q.op == xbc_pkg::XBC_OP_DRD) || (cur_q.op == xbc_pkg::XBC_OP_BUS_RD);
    assign is_wr = (cur_q.op == xbc_pkg::XBC_OP_DWR) || (cur_q.op == xbc_pkg::XBC_OP_BUS_WR);

    always_ff @(posedge clk) begin
        if (srst) begin
            addr_latch_strobe <= 1'b0;
            prog_store_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            expander_strobe_n <= 1'b1;
            internal_fetch <= 1'b0;
        end else begin
            addr_latch_strobe <= run_ph && (ph_q < `XBC_ALE_END);
            prog_store_strobe_n <= !(stb_ph && ext_f);
            read_strobe_n <= !(stb_ph && is_rd);
            write_strobe_n <= !(stb_ph && is_wr);
            expander_strobe_n <= !(stb_ph && cur_q.op == xbc_pkg::XBC_OP_EXP);
            internal_fetch <= (cur_q.op == xbc_pkg::XBC_OP_FETCH) && !ext_f;
        end
    end

    // ==========================================
    // multiplexed bus drive; write data held in output latch
    logic [7:0] out_latch_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            mux_bus_out <= 8'h00;
            mux_bus_oe <= 1'b0;
            out_latch_q <= 8'h00;
        end else begin
            if (run_ph && ph_q == 5'h00 && is_wr) begin
                out_latch_q <= cur_q.wdata;
            end
            if (adr_ph && ext_f) begin
                mux_bus_out <= cur_q.pc[7:0];
                mux_bus_oe <= 1'b1;
            end else if (adr_ph && (cur_q.op == xbc_pkg::XBC_OP_DRD ||
                                    cur_q.op == xbc_pkg::XBC_OP_DWR)) begin
                mux_bus_out <= cur_q.addr;
                mux_bus_oe <= 1'b1;
            end else if (is_wr && !adr_ph) begin
                // latch keeps driving so data outlasts the write strobe
                mux_bus_out <= out_latch_q;
                mux_bus_oe <= run_ph;
            end else begin
                mux_bus_oe <= 1'b0;
            end
        end
    end

    // ==========================================
    // read capture at the end of the strobe window
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            if (run_ph && ph_q == `XBC_STB_END - 5'h01 && (ext_f || is_rd)) begin
                rdata <= mux_bus_in;
                rdata_valid <= 1'b1;
            end
        end
    end

    // ==========================================
    // ports: quasi-bidir latches, reset to ones
    logic [7:0] p1_q, p2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            p1_q <= `XBC_PORT_RST;
            p2_q <= `XBC_PORT_RST;
            pc_cur <= `XBC_PC_RST;
        end else begin
            if (port_one_we) p1_q <= port_one_wr;
            if (port_two_we) p2_q <= port_two_wr;
            if (run_ph && ph_q == 5'h00) pc_cur <= cur_q.pc;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            port_one_out <= `XBC_PORT_RST;
            port_two_out <= `XBC_PORT_RST;
            port_two_oe <= 8'h00;
        end else begin
            port_one_out <= p1_q;
            if (ext_f && run_ph) begin
                port_two_out <= {p2_q[7:4], cur_q.pc[11:8]};
                port_two_oe <= 8'h0f;
            end else if (cur_q.op == xbc_pkg::XBC_OP_EXP && run_ph) begin
                port_two_out <= {p2_q[7:4], cur_q.exp_nib};
                port_two_oe <= 8'h0f;
            end else begin
                // oe only marks the strong low; ones are weak pull-ups
                port_two_out <= p2_q;
                port_two_oe <= ~p2_q;
            end
        end
    end
    always_ff @(posedge clk) begin
        port_one_sync <= filt_q[12:5];
        port_two_sync <= filt_q[20:13];
    end

    // ==========================================
    // test, interrupt and counter pins
    logic clk_out_en_q, cnt_run_q, t1_prev_q;
    logic [3:0] div_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_out_en_q <= 1'b0;
            cnt_run_q <= 1'b0;
            t1_prev_q <= 1'b1;
            count_pulse <= 1'b0;
            div_q <= 4'h0;
            test_zero_out <= 1'b0;
            test_zero_oe <= 1'b0;
            jump_on_test_zero <= 1'b0;
            jump_on_test_one <= 1'b0;
            irq_req <= 1'b0;
            jump_on_irq <= 1'b0;
        end else begin
            if (clock_out_enable_instr) clk_out_en_q <= 1'b1;
            if (start_counter_instr) cnt_run_q <= 1'b1;
            else if (stop_counter_instr) cnt_run_q <= 1'b0;
            t1_prev_q <= t1_s;
            count_pulse <= cnt_run_q && t1_prev_q && !t1_s;
            div_q <= (div_q == `XBC_CLK_DIV) ? 4'h0 : div_q + 4'h1;
            if (div_q == `XBC_CLK_DIV) test_zero_out <= !test_zero_out;
            test_zero_oe <= clk_out_en_q;
            jump_on_test_zero <= t0_s;
            jump_on_test_one <= t1_s;
            irq_req <= !irqn_s;
            jump_on_irq <= !irqn_s;
        end
    end

    // ==========================================
    // checks
    AST_ALE_ONCE: assert property (@(posedge clk) disable iff (srst)
        $rose(addr_latch_strobe) |=> addr_latch_strobe ##1 !addr_latch_strobe[*8])
        else $error("address strobe not single per cycle");
    AST_RD_ONLY: assert property (@(posedge clk) disable iff (srst)
        !read_strobe_n |-> is_rd) else $error("read strobe without read");
    AST_WR_ONLY: assert property (@(posedge clk) disable iff (srst)
        !write_strobe_n |-> is_wr) else $error("write strobe without write");
    AST_PS_NOT_ALE: assert property (@(posedge clk) disable iff (srst)
        !prog_store_strobe_n |-> !addr_latch_strobe && !mux_bus_oe)
        else $error("program strobe overlaps address");
    AST_WR_DATA: assert property (@(posedge clk) disable iff (srst)
        $fell(write_strobe_n) |-> mux_bus_oe && mux_bus_out == out_latch_q)
        else $error("write strobe without latched data");
    AST_PORT_RST: assert property (@(posedge clk)
        $past(srst) |-> port_one_out == `XBC_PORT_RST && port_two_oe == 8'h00)
        else $error("ports not high after reset");
    AST_STB_EXCL: assert property (@(posedge clk) disable iff (srst)
        $onehot0({!prog_store_strobe_n, !read_strobe_n, !write_strobe_n, !expander_strobe_n}))
        else $error("strobes overlap");
    AST_HALT: assert property (@(posedge clk) disable iff (srst)
        seq_q == ST_HALT |=> !addr_latch_strobe) else $error("strobe during halt");
endmodule : xbc_bus
`default_nettype wire

// File: verif/xbc_ext_mem.sv
// Purpose: external program and data memory beside the bus controller
// Assumes: controller releases the bus whenever its oe is low
// Notes: a released bus shows a toggling pattern, never the last byte
`default_nettype none
module xbc_ext_mem (
    input wire logic clk,
    input wire logic ale,
    input wire logic prog_store_strobe_n_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    input wire logic [3:0] pc_hi,
    output logic [7:0] bus_in,
    output logic [7:0] lat_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    // ==========================================
    // address latch and storage
    always @(negedge ale) lat_addr = bus_out;
    always @(posedge clk) begin
        last_q <= bus_in;
        if (!wr_n && bus_oe) mem[lat_addr] <= bus_out;
    end
    // ==========================================
    // bus level seen by the controller
    always @* begin
        if (bus_oe) bus_in = bus_out;
        else if (!prog_store_strobe_n_n) bus_in = lat_addr ^ {pc_hi, 4'h0} ^ 8'h96;
        else if (!rd_n) bus_in = mem[lat_addr];
        else bus_in = ~last_q;
    end
endmodule : xbc_ext_mem
`default_nettype wire

// File: verif/test_mcu_external_bus_and_port_control.sv
// Purpose: self-checking bench for the external bus controller
// Assumes: inputs move 1 ns after the rising edge
// Notes: watch gathers strobe counts over a span of cycles
`default_nettype none
module test_mcu_external_bus_and_port_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, port_one_we = 0, port_two_we = 0, force_external_fetch = 0;
    logic clock_out_enable_instr = 0, start_counter_instr = 0, stop_counter_instr = 0;
    logic single_step_n = 1, irq_n = 1, test_in_zero = 1, test_in_one = 1;
    logic [7:0] port_one_wr = 8'h00, port_two_wr = 8'h00, p1_ext = 8'hff, port_one_in;
    logic [7:0] port_two_in, mux_bus_in, mux_bus_out, lat, rdata, port_one_out, got;
    logic [7:0] port_two_out, port_two_oe, port_one_sync, port_two_sync;
    logic [11:0] pc_cur;
    logic [3:0] hi;
    logic req_ready, rdata_valid, internal_fetch, mux_bus_oe, addr_latch_strobe;
    logic prog_store_strobe_n, read_strobe_n, write_strobe_n, expander_strobe_n;
    logic test_zero_out, test_zero_oe, jump_on_test_zero, jump_on_test_one;
    logic irq_req, jump_on_irq, count_pulse;
    xbc_pkg::xbc_req_type req = '0;
    int failures = 0, check_count = 0, n_ale, n_ps, n_rd, n_wr, n_ex, n_int, n_cnt, n_t0;
    // quasi pins: outside world can only pull low
    assign port_one_in = port_one_out & p1_ext;
    assign port_two_in = port_two_out;
    xbc_bus i_dut (
        .clk, .srst, .req, .clock_out_enable_instr, .start_counter_instr,
        .stop_counter_instr, .port_one_wr, .port_one_we, .port_two_wr, .port_two_we,
        .req_ready, .rdata, .rdata_valid, .pc_cur, .internal_fetch, .mux_bus_in,
        .mux_bus_out, .mux_bus_oe, .addr_latch_strobe, .prog_store_strobe_n,
        .read_strobe_n, .write_strobe_n, .expander_strobe_n, .port_one_in, .port_one_out,
        .port_two_in, .port_two_out, .port_two_oe, .force_external_fetch, .single_step_n,
        .irq_n, .test_in_zero, .test_in_one, .test_zero_out, .test_zero_oe,
        .jump_on_test_zero, .jump_on_test_one, .irq_req, .jump_on_irq, .count_pulse,
        .port_one_sync, .port_two_sync
    );
    xbc_ext_mem i_mem (
        .clk, .ale(addr_latch_strobe), .prog_store_strobe_n_n(prog_store_strobe_n), .rd_n(read_strobe_n),
        .wr_n(write_strobe_n), .bus_out(mux_bus_out), .bus_oe(mux_bus_oe),
        .pc_hi(port_two_out[3:0]), .bus_in(mux_bus_in), .lat_addr(lat)
    );
    always #5 clk = ~clk;
    // ==========================================
    // shared tasks
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] seen);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic watch(input int n);
        logic pa = 1'b0;
        logic pt = test_zero_out;
        {n_ale, n_ps, n_rd, n_wr, n_ex, n_int, n_cnt, n_t0} = '0;
        hi = 'x;
        got = 'x;
        repeat (n) begin
            step();
            n_ale += int'(addr_latch_strobe && !pa);
            pa = addr_latch_strobe;
            n_ps += int'(!prog_store_strobe_n);
            n_rd += int'(!read_strobe_n);
            n_wr += int'(!write_strobe_n);
            n_ex += int'(!expander_strobe_n);
            n_int += int'(internal_fetch);
            n_cnt += int'(count_pulse);
            n_t0 += int'(test_zero_out !== pt);
            pt = test_zero_out;
            if (!prog_store_strobe_n || !expander_strobe_n) hi = port_two_out[3:0];
            if (rdata_valid) got = rdata;
        end
    endtask : watch
    task automatic do_req(input xbc_pkg::xbc_op_type op, input logic [11:0] pc,
                          input logic [7:0] ad, input logic [3:0] nb);
        req = {op, pc, ad, ad ^ 8'hff, nb};
        for (int i = 0; i < 40 && req_ready !== 1'b1; i++) step();
        chk("ready", 12'h001, {11'h0, req_ready});
        step();
        req.op = xbc_pkg::XBC_OP_NONE;
        watch(16);
    endtask : do_req
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("p1", 12'h0ff, {4'h0, port_one_out});
        chk("p2", 12'h0ff, {4'h0, port_two_out});
        chk("pc", 12'h000, pc_cur);
        chk("oe", 12'h000, {11'h0, mux_bus_oe});
    endtask : t_reset
    task automatic t_ops();
        xbc_pkg::xbc_op_type ops[7] = '{xbc_pkg::XBC_OP_NONE, xbc_pkg::XBC_OP_FETCH,
            xbc_pkg::XBC_OP_DRD, xbc_pkg::XBC_OP_DWR, xbc_pkg::XBC_OP_BUS_RD,
            xbc_pkg::XBC_OP_BUS_WR, xbc_pkg::XBC_OP_EXP};
        logic [3:0] stb[7] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h4, 4'h2, 4'h1};
        force_external_fetch = 1'b1;
        watch(4);
        for (int i = 0; i < 7; i++) begin
            do_req(ops[i], 12'h3a5, 8'h40, 4'h9);
            chk("ale", 12'h001, 12'(n_ale));
            chk("stb", {8'h0, stb[i]}, {8'h0, n_ps > 0, n_rd > 0, n_wr > 0, n_ex > 0});
        end
    endtask : t_ops
    task automatic t_mem();
        do_req(xbc_pkg::XBC_OP_FETCH, 12'h3a5, 8'h00, 4'h0);
        chk("addr", 12'h0a5, {4'h0, lat});
        chk("pc_hi", 12'h003, {8'h0, hi});
        chk("instr", 12'h0a5 ^ 12'h030 ^ 12'h096, {4'h0, got});
        chk("pc_run", 12'h3a5, pc_cur);
        force_external_fetch = 1'b0;
        watch(4);
        do_req(xbc_pkg::XBC_OP_FETCH, 12'h3a5, 8'h00, 4'h0);
        chk("internal", 12'h001, {11'h0, n_ps == 0 && n_int > 0});
        do_req(xbc_pkg::XBC_OP_FETCH, 12'h401, 8'h00, 4'h0);
        chk("ext_hi", 12'h001, {11'h0, n_ps > 0});
        do_req(xbc_pkg::XBC_OP_DWR, 12'h000, 8'h33, 4'h0);
        chk("waddr", 12'h033, {4'h0, lat});
        do_req(xbc_pkg::XBC_OP_DRD, 12'h000, 8'h33, 4'h0);
        chk("rdata", 12'h0cc, {4'h0, got});
        do_req(xbc_pkg::XBC_OP_EXP, 12'h000, 8'h00, 4'h6);
        chk("nibble", 12'h006, {8'h0, hi});
    endtask : t_mem
    task automatic t_pins();
        p1_ext = 8'h0f;
        port_one_wr = 8'h5a;
        port_one_we = 1'b1;
        port_two_wr = 8'hc3;
        port_two_we = 1'b1;
        step();
        port_one_we = 1'b0;
        port_two_we = 1'b0;
        watch(6);
        chk("p1_out", 12'h05a, {4'h0, port_one_out});
        chk("p1_low", 12'h00a, {4'h0, port_one_sync});
        chk("p2_oe", 12'h03c, {4'h0, port_two_oe});
        chk("p2_in", 12'h0c3, {4'h0, port_two_sync});
        port_one_wr = 8'hff;
        port_one_we = 1'b1;
        step();
        port_one_we = 1'b0;
        test_in_zero = 1'b0;
        irq_n = 1'b0;
        clock_out_enable_instr = 1'b1;
        step();
        clock_out_enable_instr = 1'b0;
        watch(6);
        chk("p1_in", 12'h00f, {4'h0, port_one_sync});
        chk("t0", 12'h000, {11'h0, jump_on_test_zero});
        chk("irq", 12'h001, {11'h0, irq_req});
        chk("irq_jump", 12'h001, {11'h0, jump_on_irq});
        watch(24);
        chk("t0_clk", 12'h008, {11'h0, test_zero_oe} << 3 & 12'(n_t0));
        for (int i = 0; i < 5; i++) begin
            start_counter_instr = (i == 1);
            stop_counter_instr = (i == 4);
            step();
            start_counter_instr = 1'b0;
            stop_counter_instr = 1'b0;
            test_in_one = 1'b0;
            watch(8);
            chk("count", {11'h0, i > 0 && i < 4}, 12'(n_cnt));
            chk("t1", 12'h000, {11'h0, jump_on_test_one});
            test_in_one = 1'b1;
            watch(8);
        end
    endtask : t_pins
    task automatic t_step();
        single_step_n = 1'b0;
        watch(4);
        do_req(xbc_pkg::XBC_OP_FETCH, 12'h410, 8'h00, 4'h0);
        watch(48);
        chk("halt", 12'h000, 12'(n_ale));
        single_step_n = 1'b1;
        watch(40);
        chk("resume", 12'h001, {11'h0, n_ale > 0});
    endtask : t_step
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        watch(2);
        t_reset();
        t_ops();
        t_mem();
        t_pins();
        t_step();
        wrap_up();
    end
    // whole run is well under 2000 cycles; 10000 means a hang
    initial begin
        #100us;
        failures++;
        wrap_up();
    end
endmodule : test_mcu_external_bus_and_port_control
`default_nettype wire
